// ---- core/acc_div.sv ----
// Sequential restoring divider used by the statistics engine
`default_nettype none
module acc_div
  import acc_stats_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Operands
  input wire logic go,
  input wire logic [63:0] dvd,
  input wire logic [63:0] dvs,
  // Result
  output logic [63:0] quo,
  output logic done
);
  typedef struct packed {
    logic [63:0] rem;
    logic [63:0] q;
    logic [6:0] cnt;
    logic busy;
    logic done;
  } div_s;

  div_s s_r;
  div_s s_nxt;
  logic [65:0] trial;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    trial = {1'b0, s_r.rem, s_r.q[63]} - {2'b00, dvs};
    // A new start simply restarts; stale runs are dropped
    if (go) begin
      s_nxt.rem = '0;
      s_nxt.q = dvd;
      s_nxt.cnt = DIV_STEPS;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      s_nxt.rem = trial[65] ? {s_r.rem[62:0], s_r.q[63]} : trial[63:0];
      s_nxt.q = {s_r.q[62:0], ~trial[65]};
      s_nxt.cnt = s_r.cnt - 7'h01;
      if (s_r.cnt == 7'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign quo = s_r.q;
  assign done = s_r.done;
endmodule : acc_div
`default_nettype wire

// ---- core/acc_sqrt.sv ----
// Sequential integer square root used by the statistics engine
`default_nettype none
module acc_sqrt
  import acc_stats_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Operand
  input wire logic go,
  input wire logic [63:0] rad,
  // Result
  output logic [31:0] root,
  output logic done
);
  typedef struct packed {
    logic [63:0] x;
    logic [33:0] rem;
    logic [31:0] root;
    logic [5:0] cnt;
    logic busy;
    logic done;
  } sq_s;

  sq_s s_r;
  sq_s s_nxt;
  logic [34:0] part;
  logic [35:0] trial;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    part = {s_r.rem[32:0], s_r.x[63:62]};
    trial = {1'b0, part} - {2'b00, s_r.root, 2'b01};
    if (go) begin
      s_nxt.x = rad;
      s_nxt.rem = '0;
      s_nxt.root = '0;
      s_nxt.cnt = SQ_STEPS;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      s_nxt.x = {s_r.x[61:0], 2'b00};
      s_nxt.rem = trial[35] ? part[33:0] : trial[33:0];
      s_nxt.root = {s_r.root[30:0], ~trial[35]};
      s_nxt.cnt = s_r.cnt - 6'h01;
      if (s_r.cnt == 6'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign root = s_r.root;
  assign done = s_r.done;
endmodule : acc_sqrt
`default_nettype wire

// ---- core/acc_stats.sv ----
// Weight accumulation and running statistics with APB registers
//
// Behaviour
// - Count never passes 10000 stored accumulations.
// - Accumulation error stays high while count equals 10000.
// - Accumulation error can be routed to output line three.
// - Error blocks only accumulation; printing and weighing continue.
// - Accumulated weight is gross or net, as over/under selection picks.
// - Keep average, max, min, both deviations, count, latest and range.
// - Input line set to accumulate acts on each rising edge.
// - Serial accumulate command then carriage return accumulates, no reply.
// - Fieldbus accumulate bit rising edge accumulates; bit depends on stations.
// - Clear resets count, total and every statistic together.
// - Password 1235 written to the password entry clears.
// - Input line set to clear acts on each rising edge.
// - Serial clear command then carriage return clears, no reply.
// - Fieldbus clear bit rising edge clears; bit depends on stations.
// - Auto mode accumulates once each time complete turns on.
// - Auto accumulation also issues one print pulse.
// - With judging off, auto skips negative or over-scale weights.
//
// Chosen here: register access over APB and the placing of the registers.
`default_nettype none
module acc_stats
  import acc_stats_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire apb_req_s apb_req,
  output var apb_rsp_s apb_rsp,
  // Weighing sequence
  input wire weigh_s weigh,
  // Selectable input lines
  input wire logic [3:0] sel_in,
  // Serial command bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Fieldbus output bits from the master
  input wire logic [31:0] fb_ry,
  // Output line three
  input wire logic out3_alt,
  output logic sel_out3,
  // Status
  output logic acc_err,
  output logic auto_print,
  output logic irq
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic [CW-1:0] count;
    logic [31:0] total;
    logic [47:0] sumsq;
    logic [W-1:0] maxv;
    logic [W-1:0] minv;
    logic [W-1:0] last;
    logic [31:0] avg;
    logic [31:0] psd;
    logic [31:0] ssd;
    logic [3:0] pin_q;
    logic [1:0] fb_q;
    logic cmp_q;
    parse_e ps;
    stat_e st;
    logic [CW-1:0] ncnt;
    logic dirty;
    logic neg;
    logic err;
    logic out3;
    logic print;
    logic [63:0] var_num;
    logic [63:0] dvd;
    logic [63:0] dvs;
    logic [63:0] rad;
    logic div_go;
    logic sq_go;
  } main_s;

  main_s s_r;
  main_s s_nxt;
  logic [63:0] quo;
  logic div_done;
  logic [31:0] root;
  logic sq_done;
  logic acc_req, clr_req, auto_req, full, wr, skip;
  logic acc_pin, acc_ser, acc_fb, clr_pin, clr_ser, clr_fb, clr_pw;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] w1c;
  logic [W-1:0] wsel;
  logic signed [63:0] tot_s;
  logic [31:0] tot_abs;
  logic [63:0] cnt_w;
  logic [W:0] rng;
  logic [31:0] rd;
  logic mapped;

  function automatic logic [1:0] line_fn(input logic [31:0] c, input logic [1:0] i);
    line_fn = c[CTRL_SEL_LSB + 2 * i +: 2];
  endfunction : line_fn

  function automatic logic [4:0] fb_bit(input logic single, input logic clr);
    if (clr) begin
      fb_bit = single ? FB_CLR_SINGLE : FB_CLR_MULTI;
    end else begin
      fb_bit = single ? FB_ACC_SINGLE : FB_ACC_MULTI;
    end
  endfunction : fb_bit

  acc_div u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(s_r.div_go),
    .dvd(s_r.dvd),
    .dvs(s_r.dvs),
    .quo(quo),
    .done(div_done)
  );

  acc_sqrt u_sqrt (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(s_r.sq_go),
    .rad(s_r.rad),
    .root(root),
    .done(sq_done)
  );

  always_comb begin
    s_nxt = s_r;
    acc_pin = 1'b0;
    clr_pin = 1'b0;
    acc_ser = 1'b0;
    clr_ser = 1'b0;
    clr_pw = 1'b0;
    ev = '0;
    s_nxt.print = 1'b0;
    s_nxt.div_go = 1'b0;
    s_nxt.sq_go = 1'b0;
    wsel = s_r.ctrl[CTRL_NET] ? weigh.net : weigh.gross;
    skip = s_r.ctrl[CTRL_JUDGE_OFF] && (wsel[W-1] || weigh.over_scale);
    full = (s_r.count == ACC_LIMIT);
    tot_s = 64'($signed(s_r.total));
    tot_abs = s_r.total[31] ? 32'(-s_r.total) : s_r.total;
    cnt_w = 64'(s_r.ncnt);
    s_nxt.pin_q = sel_in;
    s_nxt.cmp_q = weigh.complete;
    s_nxt.fb_q[0] = fb_ry[fb_bit(s_r.ctrl[CTRL_FB_SINGLE], 1'b0)];
    s_nxt.fb_q[1] = fb_ry[fb_bit(s_r.ctrl[CTRL_FB_SINGLE], 1'b1)];
    // Input lines: one edge per line, function chosen per line
    for (int i = 0; i < 4; i++) begin
      if (sel_in[i] && !s_r.pin_q[i]) begin
        if (line_fn(s_r.ctrl, 2'(i)) == SEL_ACC) acc_pin = 1'b1;
        if (line_fn(s_r.ctrl, 2'(i)) == SEL_CLR) clr_pin = 1'b1;
      end
    end
    // Serial commands: no reply is ever produced
    if (rx_valid) begin
      s_nxt.ps = (rx_data == CH_C) ? PS_C : PS_IDLE;
      case (s_r.ps)
        PS_IDLE: ;
        PS_C: begin
          if (rx_data == CH_I) s_nxt.ps = PS_I;
          if (rx_data == CH_J) s_nxt.ps = PS_J;
        end
        PS_I: acc_ser = (rx_data == CH_CR);
        PS_J: clr_ser = (rx_data == CH_CR);
        default: s_nxt.ps = PS_IDLE;
      endcase
    end
    acc_fb = s_nxt.fb_q[0] && !s_r.fb_q[0];
    clr_fb = s_nxt.fb_q[1] && !s_r.fb_q[1];
    // Auto mode: complete rising edge, print regardless of the limit
    auto_req = s_r.ctrl[CTRL_AUTO] && weigh.complete && !s_r.cmp_q && !skip;
    s_nxt.print = auto_req;
    // Register writes
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    w1c = '0;
    if (wr) begin
      case (apb_req.paddr)
        OFF_CTRL: s_nxt.ctrl = apb_req.pwdata;
        OFF_STATUS: w1c = apb_req.pwdata[NEV-1:0];
        OFF_MASK: s_nxt.mask = apb_req.pwdata[NEV-1:0];
        OFF_PASS: clr_pw = (apb_req.pwdata == CLEAR_PASSWORD);
        default: ;
      endcase
    end
    acc_req = acc_pin || acc_ser || acc_fb || auto_req;
    clr_req = clr_pin || clr_ser || clr_fb || clr_pw;
    // Statistics engine; one divider and one root shared in turn
    case (s_r.st)
      ST_IDLE: begin
        if (s_r.dirty) begin
          s_nxt.dirty = 1'b0;
          s_nxt.ncnt = s_r.count;
          s_nxt.var_num = 64'(s_r.count) * 64'(s_r.sumsq) - tot_s * tot_s;
          s_nxt.dvd = 64'(tot_abs);
          s_nxt.dvs = 64'(s_r.count);
          s_nxt.neg = s_r.total[31];
          s_nxt.div_go = 1'b1;
          s_nxt.st = ST_AVG;
        end
      end
      ST_AVG: begin
        if (div_done) begin
          s_nxt.avg = s_r.neg ? 32'(-quo[31:0]) : quo[31:0];
          s_nxt.dvd = s_r.var_num;
          s_nxt.dvs = cnt_w * cnt_w;
          s_nxt.div_go = 1'b1;
          s_nxt.st = ST_PVAR;
        end
      end
      ST_PVAR: begin
        if (div_done) begin
          s_nxt.rad = quo;
          s_nxt.sq_go = 1'b1;
          s_nxt.st = ST_PSQ;
        end
      end
      ST_PSQ: begin
        if (sq_done) begin
          s_nxt.psd = root;
          if (s_r.ncnt > 14'h0001) begin
            s_nxt.dvd = s_r.var_num;
            s_nxt.dvs = cnt_w * (cnt_w - 64'h1);
            s_nxt.div_go = 1'b1;
            s_nxt.st = ST_SVAR;
          end else begin
            s_nxt.ssd = '0;
            s_nxt.st = ST_IDLE;
            ev[EV_STATS] = 1'b1;
          end
        end
      end
      ST_SVAR: begin
        if (div_done) begin
          s_nxt.rad = quo;
          s_nxt.sq_go = 1'b1;
          s_nxt.st = ST_SSQ;
        end
      end
      ST_SSQ: begin
        if (sq_done) begin
          s_nxt.ssd = root;
          s_nxt.st = ST_IDLE;
          ev[EV_STATS] = 1'b1;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Clear outranks accumulate in the same cycle
    if (clr_req) begin
      s_nxt.count = '0;
      s_nxt.total = '0;
      s_nxt.sumsq = '0;
      s_nxt.maxv = '0;
      s_nxt.minv = '0;
      s_nxt.last = '0;
      s_nxt.avg = '0;
      s_nxt.psd = '0;
      s_nxt.ssd = '0;
      s_nxt.dirty = 1'b0;
      s_nxt.st = ST_IDLE;
      ev[EV_CLR] = 1'b1;
    end else if (acc_req) begin
      if (full) begin
        ev[EV_REFUSED] = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 14'h0001;
        s_nxt.total = s_r.total + 32'($signed(wsel));
        s_nxt.sumsq = s_r.sumsq + 48'($signed(wsel)) * 48'($signed(wsel));
        if (s_r.count == '0 || $signed(wsel) > $signed(s_r.maxv)) s_nxt.maxv = wsel;
        if (s_r.count == '0 || $signed(wsel) < $signed(s_r.minv)) s_nxt.minv = wsel;
        s_nxt.last = wsel;
        s_nxt.dirty = 1'b1;
        ev[EV_ACC] = 1'b1;
      end
    end
    // Event set wins over a simultaneous write-one-to-clear
    s_nxt.status = (s_r.status & ~w1c) | ev;
    s_nxt.err = (s_nxt.count == ACC_LIMIT);
    s_nxt.out3 = s_nxt.ctrl[CTRL_ROUTE3] ? s_nxt.err : out3_alt;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      s_r.mask <= MASK_RESET;
      s_r.ps <= PS_IDLE;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read side; password entry reads as zero
  always_comb begin
    rng = {s_r.maxv[W-1], s_r.maxv} - {s_r.minv[W-1], s_r.minv};
    mapped = 1'b1;
    case (apb_req.paddr)
      OFF_CTRL: rd = s_r.ctrl;
      OFF_STATUS: rd = 32'(s_r.status);
      OFF_MASK: rd = 32'(s_r.mask);
      OFF_PASS: rd = '0;
      OFF_COUNT: rd = 32'(s_r.count);
      OFF_TOTAL: rd = s_r.total;
      OFF_MAX: rd = 32'($signed(s_r.maxv));
      OFF_MIN: rd = 32'($signed(s_r.minv));
      OFF_LAST: rd = 32'($signed(s_r.last));
      OFF_RANGE: rd = 32'(rng);
      OFF_AVG: rd = s_r.avg;
      OFF_PSD: rd = s_r.psd;
      OFF_SSD: rd = s_r.ssd;
      OFF_STATE: rd = {26'h0000000, s_r.st != ST_IDLE || s_r.dirty, 4'h0, s_r.err};
      default: begin
        rd = '0;
        mapped = 1'b0;
      end
    endcase
    apb_rsp.prdata = rd;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  end

  assign acc_err = s_r.err;
  assign sel_out3 = s_r.out3;
  assign auto_print = s_r.print;
  assign irq = |(s_r.status & s_r.mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence acc_ok;
    !clr_req && !full;
  endsequence
  sequence count_up;
    s_r.count == $past(s_r.count) + 14'h0001;
  endsequence
  sequence ser_acc;
    (rx_valid && rx_data == CH_C) ##1 (rx_valid && rx_data == CH_I)
      ##1 ((rx_valid && rx_data == CH_CR) and acc_ok);
  endsequence
  sequence ser_clr;
    (rx_valid && rx_data == CH_C) ##1 (rx_valid && rx_data == CH_J) ##1 (rx_valid && rx_data == CH_CR);
  endsequence
  sequence cleared;
    s_r.count == '0 && s_r.total == '0 && s_r.sumsq == '0 && s_r.avg == '0 && s_r.psd == '0;
  endsequence

  count_limit_a: assert property (s_r.count <= ACC_LIMIT) else $error("count above limit");
  err_level_a: assert property (acc_err == (s_r.count == ACC_LIMIT)) else $error("error level wrong");
  refuse_full_a: assert property (full && !clr_req |=> s_r.count == ACC_LIMIT)
    else $error("count left the limit without a clear");
  refuse_hold_a: assert property (acc_req && !clr_req && full |=> $stable(s_r.count) && s_r.status[EV_REFUSED]) else $error("limit not held");
  route_out_a: assert property (s_r.ctrl[CTRL_ROUTE3] && !(wr && apb_req.paddr == OFF_CTRL) |=> sel_out3 == acc_err) else $error("route wrong");
  print_full_a: assert property (auto_req && full |=> auto_print) else $error("print lost at limit");
  weight_sel_a: assert property (acc_req and acc_ok |=> s_r.last == $past(wsel))
    else $error("wrong weight");
  stats_done_a: assert property ($rose(s_r.st == ST_AVG) |-> ##[1:400] s_r.st == ST_IDLE) else $error("stats stuck");
  pin_acc_a: assert property (acc_pin and acc_ok |=> count_up)
    else $error("pin accumulate lost");
  serial_acc_a: assert property (ser_acc |=> count_up) else $error("serial accumulate lost");
  fb_acc_a: assert property (acc_fb and acc_ok |=> count_up)
    else $error("fieldbus accumulate lost");
  clear_all_a: assert property (clr_req |=> cleared) else $error("clear incomplete");
  pass_clear_a: assert property (wr && apb_req.paddr == OFF_PASS && apb_req.pwdata == CLEAR_PASSWORD |=> cleared) else $error("password clear lost");
  pin_clear_a: assert property (clr_pin |=> cleared) else $error("pin clear lost");
  serial_clear_a: assert property (ser_clr |=> cleared) else $error("serial clear lost");
  fb_clear_a: assert property (clr_fb |=> cleared ##1 !clr_fb) else $error("fieldbus clear lost");
  auto_acc_a: assert property (
    (s_r.ctrl[CTRL_AUTO] && $rose(weigh.complete) && !skip) and acc_ok |=> count_up)
    else $error("auto accumulate lost");
  auto_print_a: assert property (auto_req |=> auto_print ##1 !auto_print) else $error("print pulse wrong");
  auto_skip_a: assert property (skip && !acc_pin && !acc_ser && !acc_fb && !clr_req |=> $stable(s_r.count)) else $error("skip ignored");
  clear_wins_a: assert property (acc_req && clr_req |=> s_r.count == '0 &&
    (!s_r.status[EV_ACC] || $past(s_r.status[EV_ACC]))) else $error("accumulate beat clear");
endmodule : acc_stats
`default_nettype wire

// ---- core/acc_stats_pkg.sv ----
// Package: constants and carriers for the weight accumulation statistics block
`default_nettype none
package acc_stats_pkg;
  localparam int W = 16;
  localparam int CW = 14;
  localparam int NEV = 4;
  localparam logic [CW-1:0] ACC_LIMIT = 14'h2710;
  localparam logic [31:0] CLEAR_PASSWORD = 32'h000004D3;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_J = 8'h4A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [4:0] FB_ACC_MULTI = 5'h18;
  localparam logic [4:0] FB_ACC_SINGLE = 5'h08;
  localparam logic [4:0] FB_CLR_MULTI = 5'h19;
  localparam logic [4:0] FB_CLR_SINGLE = 5'h09;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [5:0] SQ_STEPS = 6'h20;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_PASS = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_TOTAL = 8'h14;
  localparam logic [7:0] OFF_MAX = 8'h18;
  localparam logic [7:0] OFF_MIN = 8'h1C;
  localparam logic [7:0] OFF_LAST = 8'h20;
  localparam logic [7:0] OFF_RANGE = 8'h24;
  localparam logic [7:0] OFF_AVG = 8'h28;
  localparam logic [7:0] OFF_PSD = 8'h2C;
  localparam logic [7:0] OFF_SSD = 8'h30;
  localparam logic [7:0] OFF_STATE = 8'h34;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_NET = 1;
  localparam int CTRL_JUDGE_OFF = 2;
  localparam int CTRL_ROUTE3 = 3;
  localparam int CTRL_FB_SINGLE = 4;
  localparam int CTRL_SEL_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [NEV-1:0] MASK_RESET = 4'h0;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_ACC = 2'h1;
  localparam logic [1:0] SEL_CLR = 2'h2;
  localparam int EV_ACC = 0;
  localparam int EV_CLR = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_STATS = 3;

  typedef enum logic [3:0] {
    PS_IDLE = 4'h1, PS_C = 4'h2, PS_I = 4'h4, PS_J = 4'h8
  } parse_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_AVG = 6'h02, ST_PVAR = 6'h04,
    ST_PSQ = 6'h08, ST_SVAR = 6'h10, ST_SSQ = 6'h20
  } stat_e;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [W-1:0] gross;
    logic [W-1:0] net;
    logic over_scale;
    logic complete;
  } weigh_s;
endpackage : acc_stats_pkg
`default_nettype wire

// ---- test/acc_host_model.sv ----
// Host model sending serial accumulate and clear command strings
`default_nettype none
module acc_host_model
  import acc_stats_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command request from the bench
  input wire logic go,
  input wire logic clr,
  // Serial bytes to the block
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step_r;
  logic clr_r;
  // Three bytes on consecutive pulses; no receive path, no reply is expected
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_r <= 2'h0;
      clr_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else if (step_r == 2'h0) begin
      rx_valid <= go;
      clr_r <= clr;
      step_r <= go ? 2'h1 : 2'h0;
      // Idle byte toggles so a stale value never passes for data
      rx_data <= go ? CH_C : ~rx_data;
    end else begin
      step_r <= (step_r == 2'h2) ? 2'h0 : step_r + 2'h1;
      rx_data <= (step_r == 2'h2) ? CH_CR : (clr_r ? CH_J : CH_I);
    end
  end
endmodule : acc_host_model
`default_nettype wire

// ---- test/test_acc_stats.sv ----
// Self-checking bench for the weight accumulation statistics block
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module test_acc_stats
  import acc_stats_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  weigh_s wg = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] fb = 32'h0;
  logic out3 = 1'b0;
  logic hgo = 1'b0;
  logic hclr = 1'b0;
  logic rx_valid;
  logic [7:0] rx_data;
  logic sel_out3, acc_err, auto_print, irq;
  logic [31:0] rd_q;
  logic err_q;
  logic [3:0] n;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  acc_host_model host (.clk(clk), .sys_rst(sys_rst), .go(hgo), .clr(hclr),
    .rx_valid(rx_valid), .rx_data(rx_data));
  acc_stats uut (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .weigh(wg),
    .sel_in(sel), .rx_valid(rx_valid), .rx_data(rx_data), .fb_ry(fb), .out3_alt(out3),
    .sel_out3(sel_out3), .acc_err(acc_err), .auto_print(auto_print), .irq(irq));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Hang guard: the limit run alone takes about 30000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd_q = rsp.prdata;
    err_q = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_q, e)
  endtask : rd
  task automatic line(input int i);
    @(posedge clk);
    sel[i] <= 1'b1;
    @(posedge clk);
    sel[i] <= 1'b0;
    @(posedge clk);
  endtask : line
  task automatic fb_hit(input int i);
    @(posedge clk);
    fb[i] <= 1'b1;
    @(posedge clk);
    fb[i] <= 1'b0;
    @(posedge clk);
  endtask : fb_hit
  task automatic serial(input logic c);
    @(posedge clk);
    hgo <= 1'b1;
    hclr <= c;
    @(posedge clk);
    hgo <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : serial
  // Counts print pulses around one rising edge of complete
  task automatic auto_hit();
    n = 4'h0;
    @(posedge clk);
    wg.complete <= 1'b1;
    repeat (5) begin
      @(posedge clk);
      n = n + {3'h0, auto_print === 1'b1};
    end
    wg.complete <= 1'b0;
    @(posedge clk);
  endtask : auto_hit
  task automatic acc_stat(input logic [15:0] g);
    wg.gross <= g;
    wr(OFF_STATUS, 32'h0000000F);
    line(0);
    rd_q = 32'h0;
    for (int k = 0; k < 150 && rd_q[EV_STATS] !== 1'b1; k++) apb(1'b0, OFF_STATUS, 32'h0);
  endtask : acc_stat
  task automatic t_regs();
    rd(OFF_CTRL, CTRL_RESET);
    rd(OFF_MASK, {28'h0, MASK_RESET});
    rd(OFF_COUNT, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    `CHK(err_q, 1'b1)
    `CHK(rd_q, 32'h0)
  endtask : t_regs
  task automatic t_stats();
    logic [7:0] offs [9];
    logic [31:0] exps [9];
    offs = '{OFF_COUNT, OFF_TOTAL, OFF_MAX, OFF_MIN, OFF_LAST, OFF_RANGE, OFF_AVG, OFF_PSD,
      OFF_SSD};
    exps = '{32'h2, 32'h190, 32'h12C, 32'h64, 32'h12C, 32'hC8, 32'hC8, 32'h64, 32'h8D};
    wr(OFF_CTRL, 32'h00000900);
    acc_stat(16'h0064);
    acc_stat(16'h012C);
    for (int k = 0; k < 9; k++) rd(offs[k], exps[k]);
    wr(OFF_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wr(OFF_MASK, 32'h1);
    // Register write lands at the access edge; look one edge later
    @(posedge clk);
    `CHK(irq, 1'b1)
    wr(OFF_STATUS, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wr(OFF_COUNT, 32'h7);
    `CHK(err_q, 1'b0)
    rd(OFF_COUNT, 32'h2);
  endtask : t_stats
  task automatic t_sources();
    wr(OFF_PASS, CLEAR_PASSWORD);
    rd(OFF_COUNT, 32'h0);
    rd(OFF_MAX, 32'h0);
    wr(OFF_CTRL, 32'h00000902);
    wg.net <= 16'hFFCE;
    serial(1'b0);
    rd(OFF_COUNT, 32'h1);
    rd(OFF_LAST, 32'hFFFFFFCE);
    fb_hit(24);
    rd(OFF_COUNT, 32'h2);
    wr(OFF_CTRL, 32'h00000912);
    fb_hit(24);
    fb_hit(8);
    rd(OFF_COUNT, 32'h3);
    fb_hit(9);
    rd(OFF_COUNT, 32'h0);
    line(0);
    serial(1'b1);
    rd(OFF_COUNT, 32'h0);
    line(0);
    wr(OFF_PASS, 32'h000004D2);
    rd(OFF_COUNT, 32'h1);
    line(1);
    rd(OFF_COUNT, 32'h0);
    line(0);
    @(posedge clk);
    sel <= 4'h3;
    @(posedge clk);
    sel <= 4'h0;
    rd(OFF_COUNT, 32'h0);
  endtask : t_sources
  task automatic t_auto();
    wg.gross <= 16'h0032;
    wr(OFF_CTRL, 32'h00000001);
    auto_hit();
    `CHK(n, 4'h1)
    rd(OFF_COUNT, 32'h1);
    wr(OFF_CTRL, 32'h00000005);
    wg.over_scale <= 1'b1;
    auto_hit();
    `CHK(n, 4'h0)
    wg.over_scale <= 1'b0;
    wg.gross <= 16'hFFFB;
    auto_hit();
    `CHK(n, 4'h0)
    rd(OFF_COUNT, 32'h1);
  endtask : t_auto
  task automatic t_limit();
    wr(OFF_CTRL, 32'h00000908);
    line(1);
    repeat (9999) line(0);
    `CHK(acc_err, 1'b0)
    line(0);
    `CHK(acc_err, 1'b1)
    `CHK(sel_out3, 1'b1)
    wr(OFF_STATUS, 32'h0000000F);
    line(0);
    rd(OFF_COUNT, 32'h00002710);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd_q[EV_REFUSED], 1'b1)
    wg.gross <= 16'h0032;
    wr(OFF_CTRL, 32'h00000909);
    auto_hit();
    `CHK(n, 4'h1)
    line(1);
    `CHK(acc_err, 1'b0)
    wr(OFF_CTRL, 32'h00000900);
    out3 <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(sel_out3, 1'b1)
    line(0);
    rd(OFF_COUNT, 32'h1);
  endtask : t_limit
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK(acc_err, 1'b0)
    `CHK(irq, 1'b0)
    t_regs();
    t_stats();
    t_sources();
    t_auto();
    t_limit();
    give_verdict();
  end
endmodule : test_acc_stats
`default_nettype wire
